// >>> rtl/sioc_consts.vh
// Constants for the servo I/O signal conditioning block
`ifndef SIOC_CONSTS_VH
`define SIOC_CONSTS_VH

// Register byte offsets on the Wishbone slave
`define SIOC_OFF_OUT_SEL1 8'h00
`define SIOC_OFF_OUT_SEL2 8'h04
`define SIOC_OFF_OUT_SEL3 8'h08
`define SIOC_OFF_IN_FILT 8'h0C
`define SIOC_OFF_STOP_FN 8'h10
`define SIOC_OFF_RSVD_A 8'h14
`define SIOC_OFF_CLR_FN 8'h18
`define SIOC_OFF_RSVD_B 8'h1C
`define SIOC_OFF_WARN_FN 8'h20
`define SIOC_OFF_RSVD_C 8'h24
`define SIOC_OFF_STATE 8'h28
`define SIOC_OFF_IRQ_STAT 8'h2C
`define SIOC_OFF_IRQ_MASK 8'h30

// Reset values
`define SIOC_RST_OUT_SEL1 16'h0004
`define SIOC_RST_OUT_SEL2 16'h0002
`define SIOC_RST_OUT_SEL3 16'h0005
`define SIOC_RST_IN_FILT 16'h0002
`define SIOC_RST_STOP_FN 16'h0000
`define SIOC_RST_CLR_FN 16'h0000
`define SIOC_RST_WARN_FN 16'h0000
`define SIOC_RST_RSVD 16'h0000
`define SIOC_RST_IRQ 4'h0

// Field positions
`define SIOC_SEL_MSB 5
`define SIOC_FILT_LSB 0
`define SIOC_ACF_BIT 4
`define SIOC_DCF_BIT 8
`define SIOC_STOP_BIT 0
`define SIOC_BASE_BIT 4
`define SIOC_TOUGH_BIT 8
`define SIOC_CLRMODE_BIT 0
`define SIOC_WNG_ON_BIT 4
`define SIOC_ALM_ON_BIT 5

// Filter times in microseconds, clock in MHz
`define SIOC_CLK_MHZ 100
`define SIOC_FILT1_US 1777
`define SIOC_FILT2_US 3555
`define SIOC_FILT3_US 5333
`define SIOC_DED_US 50000

`endif

// >>> rtl/sioc_top.v
// Servo I/O signal conditioning: output routing, input filters, stop and clear control
//
// Our own choices: the Wishbone slave port and the register offsets.
`include "sioc_consts.vh"

module sioc_top #(
    parameter FILT1_CYC = `SIOC_FILT1_US * `SIOC_CLK_MHZ,
    parameter FILT2_CYC = `SIOC_FILT2_US * `SIOC_CLK_MHZ,
    parameter FILT3_CYC = `SIOC_FILT3_US * `SIOC_CLK_MHZ,
    parameter DED_CYC = `SIOC_DED_US * `SIOC_CLK_MHZ,
    parameter [5:0] TOUGH_CODE = 6'h0D,
    parameter [5:0] WARN_CODE = 6'h07,
    parameter [5:0] TROUBLE_CODE = 6'h03
) (
    input wire CLK,
    input wire RST_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    input wire ALARM_CLEAR_INPUT,
    input wire DROOP_CLEAR_INPUT,
    input wire FORWARD_LIMIT_INPUT,
    input wire REVERSE_LIMIT_INPUT,
    input wire [63:0] DEVICE_STATE,
    input wire WARNING_PRESENT,
    input wire ALARM_PRESENT,
    input wire POWER_FAIL_TOUGH,
    input wire OVERLOAD_TOUGH,
    input wire POSITION_MODE,
    output reg OUT_PIN_FIRST,
    output reg OUT_PIN_SECOND,
    output reg OUT_PIN_THIRD,
    output reg POWER_STAGE_ENABLE,
    output reg TOUGH_DRIVE_FLAG,
    output reg SUDDEN_STOP,
    output reg SLOW_STOP,
    output reg DROOP_CLEAR,
    output reg IRQ
);

    localparam CW = 23;
    // Filter limits as counts minus one, cut to the counter width on purpose
    localparam integer LIM1_I = FILT1_CYC - 1;
    localparam integer LIM2_I = FILT2_CYC - 1;
    localparam integer LIM3_I = FILT3_CYC - 1;
    localparam integer LIMD_I = DED_CYC - 1;
    localparam [CW-1:0] LIM1 = LIM1_I[CW-1:0];
    localparam [CW-1:0] LIM2 = LIM2_I[CW-1:0];
    localparam [CW-1:0] LIM3 = LIM3_I[CW-1:0];
    localparam [CW-1:0] LIMD = LIMD_I[CW-1:0];
    // Input index order: forward limit, reverse limit, alarm clear, droop clear
    localparam NIN = 4;

    // Software-visible configuration and interrupt registers
    reg [15:0] output_select_first;
    reg [15:0] output_select_second;
    reg [15:0] output_select_third;
    reg [15:0] input_filter_config;
    reg [15:0] stop_and_base_function;
    reg [15:0] droop_clear_function;
    reg [15:0] warning_output_function;
    reg [3:0] irq_status;
    reg [3:0] irq_mask;

    // Synchroniser, filter and edge-history state
    reg [NIN-1:0] sync_a;
    reg [NIN-1:0] sync_b;
    wire [NIN-1:0] filt;
    wire [1:0] ded;
    reg [NIN-1:0] filt_d;
    reg [CW-1:0] filt_lim;

    // Bus decode, conditioned inputs, decoded function bits and internal devices
    wire bus_req;
    wire bus_wr;
    wire stop_slow;
    wire base_keep;
    wire tough_ovl;
    wire clr_level;
    wire [NIN-1:0] cond;
    wire alarm_clear_input;
    wire droop_clear_input;
    wire limit_reached;
    wire [3:0] events;
    reg warning_output;
    reg trouble_output;
    reg tough_drive_flag;
    reg [63:0] dev_vec;
    reg [31:0] next_dat;
    reg next_droop_clear;

    // Byte-lane merge of a 16-bit register
    function [15:0] sioc_merge;
        input [15:0] old;
        input [31:0] dat;
        input [3:0] sel;
        begin
            sioc_merge[7:0] = sel[0] ? dat[7:0] : old[7:0];
            sioc_merge[15:8] = sel[1] ? dat[15:8] : old[15:8];
        end
    endfunction

    assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign bus_wr = bus_req & WB_WE_I;

    // Function-select bits, named once so the control logic reads plainly
    assign stop_slow = stop_and_base_function[`SIOC_STOP_BIT];
    assign base_keep = stop_and_base_function[`SIOC_BASE_BIT];
    assign tough_ovl = stop_and_base_function[`SIOC_TOUGH_BIT];
    assign clr_level = droop_clear_function[`SIOC_CLRMODE_BIT];

    // Two-stage synchronisers for the field inputs
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end else begin
            sync_a <= {DROOP_CLEAR_INPUT, ALARM_CLEAR_INPUT, REVERSE_LIMIT_INPUT,
                       FORWARD_LIMIT_INPUT};
            sync_b <= sync_a;
        end
    end

    // Selected general filter length, registered to keep the decode off the counters
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            filt_lim <= {CW{1'b0}};
        end else begin
            case (input_filter_config[`SIOC_FILT_LSB+1:`SIOC_FILT_LSB])
                2'd1: filt_lim <= LIM1;
                2'd2: filt_lim <= LIM2;
                2'd3: filt_lim <= LIM3;
                default: filt_lim <= {CW{1'b0}};
            endcase
        end
    end

    // General filter per input: a level is taken only after it held for the whole time
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi = gi + 1) begin : g_filt
            reg [CW-1:0] cnt;
            reg val;
            // Each accepted level has a flip-flop of its own, so every bit has one driver
            assign filt[gi] = val;
            always @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    cnt <= {CW{1'b0}};
                    val <= 1'b0;
                end else if (sync_b[gi] == val) begin
                    cnt <= {CW{1'b0}};
                end else if (cnt >= filt_lim) begin
                    val <= sync_b[gi];
                    cnt <= {CW{1'b0}};
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    endgenerate

    // Dedicated 50 ms filters for alarm clear and droop clear, bypassed when disabled
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ded
            reg [CW-1:0] cnt;
            wire en;
            reg val;
            assign en = (gi == 0) ? input_filter_config[`SIOC_ACF_BIT]
                                  : input_filter_config[`SIOC_DCF_BIT];
            assign ded[gi] = val;
            always @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    cnt <= {CW{1'b0}};
                    val <= 1'b0;
                end else if (!en) begin
                    val <= filt[gi+2];
                    cnt <= {CW{1'b0}};
                end else if (filt[gi+2] == val) begin
                    cnt <= {CW{1'b0}};
                end else if (cnt >= LIMD) begin
                    val <= filt[gi+2];
                    cnt <= {CW{1'b0}};
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    endgenerate

    // Conditioned inputs; a limit switch that goes off means the stroke end is reached
    assign alarm_clear_input = ded[0];
    assign droop_clear_input = ded[1];
    assign cond = {droop_clear_input, alarm_clear_input, filt[1:0]};
    assign limit_reached = ~filt[0] | ~filt[1];

    // Events: limit reached on either side, alarm clear and droop clear rising
    assign events = {cond[3] & ~filt_d[3],
                     cond[2] & ~filt_d[2],
                     ~cond[1] & filt_d[1],
                     ~cond[0] & filt_d[0]};

    // Warning and trouble outputs and tough-drive flag as internal devices
    always @* begin
        warning_output = WARNING_PRESENT & warning_output_function[`SIOC_WNG_ON_BIT];
        trouble_output = ALARM_PRESENT |
                         (WARNING_PRESENT & warning_output_function[`SIOC_ALM_ON_BIT]);
        tough_drive_flag = POWER_FAIL_TOUGH |
                           (OVERLOAD_TOUGH & tough_ovl);
        dev_vec = DEVICE_STATE;
        dev_vec[TOUGH_CODE] = tough_drive_flag;
        dev_vec[WARN_CODE] = warning_output;
        dev_vec[TROUBLE_CODE] = trouble_output;
    end

    // Droop clear request: edge or level mode, plus sudden stop in position mode
    always @* begin
        if (clr_level) begin
            next_droop_clear = droop_clear_input;
        end else begin
            next_droop_clear = droop_clear_input & ~filt_d[3];
        end
        if (limit_reached & ~stop_slow & POSITION_MODE) begin
            next_droop_clear = 1'b1;
        end
    end

    // Output pins follow the device each selector names, one cycle behind
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            OUT_PIN_FIRST <= 1'b0;
            OUT_PIN_SECOND <= 1'b0;
            OUT_PIN_THIRD <= 1'b0;
        end else begin
            OUT_PIN_FIRST <= dev_vec[output_select_first[`SIOC_SEL_MSB:0]];
            OUT_PIN_SECOND <= dev_vec[output_select_second[`SIOC_SEL_MSB:0]];
            OUT_PIN_THIRD <= dev_vec[output_select_third[`SIOC_SEL_MSB:0]];
        end
    end

    // Drive controls, all from flip-flops so the amplifier sees no decode glitches
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            POWER_STAGE_ENABLE <= 1'b0;
            TOUGH_DRIVE_FLAG <= 1'b0;
            SUDDEN_STOP <= 1'b0;
            SLOW_STOP <= 1'b0;
            DROOP_CLEAR <= 1'b0;
        end else begin
            POWER_STAGE_ENABLE <= ~(alarm_clear_input & ~base_keep);
            TOUGH_DRIVE_FLAG <= tough_drive_flag;
            SUDDEN_STOP <= limit_reached & ~stop_slow;
            SLOW_STOP <= limit_reached & stop_slow;
            DROOP_CLEAR <= next_droop_clear;
        end
    end

    // Edge history for the event detectors, and the interrupt level
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            filt_d <= 4'h0;
            IRQ <= 1'b0;
        end else begin
            filt_d <= cond;
            IRQ <= |(irq_status & irq_mask);
        end
    end

    // Configuration registers; reserved words hold zero and ignore writes
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            output_select_first <= `SIOC_RST_OUT_SEL1;
            output_select_second <= `SIOC_RST_OUT_SEL2;
            output_select_third <= `SIOC_RST_OUT_SEL3;
            input_filter_config <= `SIOC_RST_IN_FILT;
            stop_and_base_function <= `SIOC_RST_STOP_FN;
            droop_clear_function <= `SIOC_RST_CLR_FN;
            warning_output_function <= `SIOC_RST_WARN_FN;
            irq_mask <= `SIOC_RST_IRQ;
        end else if (bus_wr) begin
            case (WB_ADR_I)
                `SIOC_OFF_OUT_SEL1:
                    output_select_first <= sioc_merge(output_select_first, WB_DAT_I, WB_SEL_I);
                `SIOC_OFF_OUT_SEL2:
                    output_select_second <= sioc_merge(output_select_second, WB_DAT_I, WB_SEL_I);
                `SIOC_OFF_OUT_SEL3:
                    output_select_third <= sioc_merge(output_select_third, WB_DAT_I, WB_SEL_I);
                `SIOC_OFF_IN_FILT:
                    input_filter_config <= sioc_merge(input_filter_config, WB_DAT_I, WB_SEL_I);
                `SIOC_OFF_STOP_FN:
                    stop_and_base_function <= sioc_merge(stop_and_base_function, WB_DAT_I,
                                                         WB_SEL_I);
                `SIOC_OFF_CLR_FN:
                    droop_clear_function <= sioc_merge(droop_clear_function, WB_DAT_I, WB_SEL_I);
                `SIOC_OFF_WARN_FN:
                    warning_output_function <= sioc_merge(warning_output_function, WB_DAT_I,
                                                          WB_SEL_I);
                `SIOC_OFF_IRQ_MASK: begin
                    if (WB_SEL_I[0]) begin
                        irq_mask <= WB_DAT_I[3:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Sticky event bits; a new event in the clearing cycle wins over the clear
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_status <= `SIOC_RST_IRQ;
        end else if (bus_wr && WB_ADR_I == `SIOC_OFF_IRQ_STAT && WB_SEL_I[0]) begin
            irq_status <= (irq_status & ~WB_DAT_I[3:0]) | events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    // Read mux; unmapped and reserved offsets read zero
    always @* begin
        next_dat = 32'h0000_0000;
        case (WB_ADR_I)
            `SIOC_OFF_OUT_SEL1: next_dat[15:0] = output_select_first;
            `SIOC_OFF_OUT_SEL2: next_dat[15:0] = output_select_second;
            `SIOC_OFF_OUT_SEL3: next_dat[15:0] = output_select_third;
            `SIOC_OFF_IN_FILT: next_dat[15:0] = input_filter_config;
            `SIOC_OFF_STOP_FN: next_dat[15:0] = stop_and_base_function;
            `SIOC_OFF_RSVD_A: next_dat[15:0] = `SIOC_RST_RSVD;
            `SIOC_OFF_CLR_FN: next_dat[15:0] = droop_clear_function;
            `SIOC_OFF_RSVD_B: next_dat[15:0] = `SIOC_RST_RSVD;
            `SIOC_OFF_WARN_FN: next_dat[15:0] = warning_output_function;
            `SIOC_OFF_RSVD_C: next_dat[15:0] = `SIOC_RST_RSVD;
            `SIOC_OFF_STATE: next_dat[9:0] = {POWER_STAGE_ENABLE, DROOP_CLEAR, SLOW_STOP,
                                              SUDDEN_STOP, TOUGH_DRIVE_FLAG, 1'b0, cond};
            `SIOC_OFF_IRQ_STAT: next_dat[3:0] = irq_status;
            `SIOC_OFF_IRQ_MASK: next_dat[3:0] = irq_mask;
            default: next_dat = 32'h0000_0000;
        endcase
    end

    // Wishbone answer: one wait state, ack drops the cycle after it was given
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= bus_req;
            if (bus_req && !WB_WE_I) begin
                WB_DAT_O <= next_dat;
            end
        end
    end

endmodule

// >>> tb/sioc_properties.sv
// Port-level checker for the servo I/O conditioning block
module sioc_properties (
    input wire CLK,
    input wire RST_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire [31:0] WB_DAT_O,
    input wire WB_ACK_O,
    input wire ALARM_CLEAR_INPUT,
    input wire POWER_FAIL_TOUGH,
    input wire OVERLOAD_TOUGH,
    input wire POSITION_MODE,
    input wire POWER_STAGE_ENABLE,
    input wire TOUGH_DRIVE_FLAG,
    input wire SUDDEN_STOP,
    input wire SLOW_STOP,
    input wire DROOP_CLEAR
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain, so clock and reset are given once
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered next cycle");
    a_read_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_tough_power_fail: assert property (POWER_FAIL_TOUGH |=> TOUGH_DRIVE_FLAG)
        else $error("tough flag missing on power failure");
    a_tough_has_cause: assert property (
        TOUGH_DRIVE_FLAG |-> $past(POWER_FAIL_TOUGH || OVERLOAD_TOUGH))
        else $error("tough flag without a cause");
    a_stop_kinds_apart: assert property (!(SUDDEN_STOP && SLOW_STOP))
        else $error("sudden and slow stop together");
    a_sudden_clears_droop: assert property (
        SUDDEN_STOP && $past(POSITION_MODE) |-> DROOP_CLEAR)
        else $error("sudden stop without droop clear");
    a_power_drop_cause: assert property (
        $fell(POWER_STAGE_ENABLE) |-> $past(ALARM_CLEAR_INPUT, 2))
        else $error("power stage dropped without alarm clear");
endmodule

bind sioc_top sioc_properties u_props (.CLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_DAT_O, .WB_ACK_O,
    .ALARM_CLEAR_INPUT, .POWER_FAIL_TOUGH, .OVERLOAD_TOUGH, .POSITION_MODE, .POWER_STAGE_ENABLE,
    .TOUGH_DRIVE_FLAG, .SUDDEN_STOP, .SLOW_STOP, .DROOP_CLEAR);

// >>> tb/sioc_partner.sv
// Field switch model driving the four external input pins
module sioc_partner (
    input wire CLK,
    input wire [3:0] want,
    input wire [3:0] chat,
    output logic [3:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = 4'h0;
    // A chattering line flips every cycle, so no level lasts a filter time
    always @(posedge CLK) begin
        pins <= (want & ~chat) | (~pins & chat);
    end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the servo I/O conditioning block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK, RST_N, cyc, stb, we, wp, pft, olt, pm, ack, o1, o2, o3, pse, tdf, ss, sl, dc, irq, g;
    logic [7:0] adr;
    logic [31:0] dat, rd, q;
    logic [63:0] dev;
    logic [3:0] want, chat, pins;
    logic ap;
    logic [5:0] c [3];
    logic [31:0] seed = 32'h0000_F967;
    int miscompares = 0;
    int cmp_count = 0;
    int n;

    sioc_top #(.FILT1_CYC(8), .FILT2_CYC(16), .FILT3_CYC(24), .DED_CYC(40)) uut (
        .CLK(CLK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(dat), .WB_DAT_O(rd), .WB_ACK_O(ack),
        .ALARM_CLEAR_INPUT(pins[0]), .DROOP_CLEAR_INPUT(pins[1]), .FORWARD_LIMIT_INPUT(pins[2]),
        .REVERSE_LIMIT_INPUT(pins[3]), .DEVICE_STATE(dev), .WARNING_PRESENT(wp),
        .ALARM_PRESENT(ap), .POWER_FAIL_TOUGH(pft), .OVERLOAD_TOUGH(olt), .POSITION_MODE(pm),
        .OUT_PIN_FIRST(o1), .OUT_PIN_SECOND(o2), .OUT_PIN_THIRD(o3), .POWER_STAGE_ENABLE(pse),
        .TOUGH_DRIVE_FLAG(tdf), .SUDDEN_STOP(ss), .SLOW_STOP(sl), .DROOP_CLEAR(dc), .IRQ(irq));
    sioc_partner field (.CLK(CLK), .want(want), .chat(chat), .pins(pins));

    // Repeatable pseudo-random source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Filter length in cycles for a filter code, as shortened in this bench
    function automatic int fc(int f);
        return (f == 0) ? 1 : f * 8;
    endfunction
    function automatic logic [15:0] rv(int i);
        return (i == 0) ? 16'h0004 : (i == 1) ? 16'h0002 : (i == 2) ? 16'h0005 :
            (i == 3) ? 16'h0002 : 16'h0000;
    endfunction
    function automatic logic obs(int k);
        return (k == 0) ? !pse : (k == 1) ? dc : ss;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Classic single Wishbone cycle; read data lands in q
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge CLK);
        {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
        i = 0;
        // Ack is sampled at the rising edge; data is taken and the request dropped there
        do begin
            @(posedge CLK);
            i++;
            if (i > 20) begin
                miscompares++;
                tally_and_finish();
            end
        end while (ack !== 1'h1);
        q = rd;
        {cyc, stb} <= 2'h0;
    endtask
    // Bounded wait for an observed output to reach a level; n counts cycles
    task automatic wt(int k, logic v, int lim);
        n = 0;
        while (obs(k) !== v) begin
            @(negedge CLK);
            n++;
            if (n > lim) begin
                miscompares++;
                tally_and_finish();
            end
        end
    endtask
    // Raise one input, time its passage through the filters, then let it settle low
    task automatic ms(int k, logic [15:0] cfg, int f);
        wb(1'h1, 8'h0C, {16'h0000, cfg});
        @(posedge CLK);
        want[k] <= 1'h1;
        wt(k, 1'h1, f + 10);
        chk(n >= f + 1 && n <= f + 6, 1);
        if (k == 1) begin
            @(negedge CLK);
            chk(dc, 0);
        end
        @(posedge CLK);
        want[k] <= 1'h0;
        repeat (f + 10) @(posedge CLK);
    endtask

    initial begin
        CLK = 0;
        forever #5 CLK = ~CLK;
    end

    // Main sequence
    initial begin
        RST_N = 0;
        {cyc, stb, we, adr, dat, dev, wp, pft, olt, pm, ap} = '0;
        want = 4'hC;
        chat = 4'h0;
        repeat (5) @(posedge CLK);
        RST_N <= 1;
        dev <= {rnd(), rnd()};
        repeat (2) @(posedge CLK);
        @(negedge CLK);
        chk({o1, o2, o3}, {dev[4], dev[2], dev[5]});
        for (int i = 0; i < 11; i++) begin
            wb(1'h0, (i < 10) ? 8'(i * 4) : 8'h3C, 32'h0000_0000);
            chk(q, {16'h0000, rv(i)});
        end
        for (int j = 0; j < 3; j++) wb(1'h1, 8'(20 + j * 8), 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            for (int j = 0; j < 3; j++) begin
                c[j] = 6'(rnd());
                if (c[j] == 3 || c[j] == 7 || c[j] == 13) c[j] = c[j] + 1;
                wb(1'h1, 8'(j * 4), {26'h000_0000, c[j]});
            end
            dev <= {rnd(), rnd()};
            repeat (2) @(posedge CLK);
            @(negedge CLK);
            chk({o1, o2, o3}, {dev[c[0]], dev[c[1]], dev[c[2]]});
        end
        wb(1'h1, 8'h00, 32'h0000_0007);
        wb(1'h1, 8'h04, 32'h0000_0003);
        wp <= 1'h1;
        for (int v = 0; v < 4; v++) begin
            wb(1'h1, 8'h20, 32'(v) << 4);
            repeat (2) @(posedge CLK);
            @(negedge CLK);
            chk({o1, o2}, {v[0], v[1]});
        end
        // A present alarm drives the trouble device whatever the warning setting
        wb(1'h1, 8'h20, 32'h0000_0000);
        ap <= 1'h1;
        repeat (2) @(posedge CLK);
        @(negedge CLK);
        chk({o1, o2}, 2'h1);
        @(posedge CLK);
        {ap, olt} <= 2'h1;
        for (int b = 0; b < 2; b++) begin
            wb(1'h1, 8'h10, 32'(b) << 8);
            repeat (2) @(posedge CLK);
            @(negedge CLK);
            chk(tdf, b);
        end
        wb(1'h1, 8'h10, 32'h0000_0000);
        olt <= 1'h0;
        pft <= 1'h1;
        repeat (2) @(posedge CLK);
        @(negedge CLK);
        chk(tdf, 1);
        wt(2, 1'h0, 60);
        @(posedge CLK);
        {pft, pm, want[2]} <= 3'h2;
        wt(2, 1'h1, 40);
        chk({dc, sl}, 2'h2);
        wb(1'h1, 8'h10, 32'h0000_0001);
        repeat (2) @(posedge CLK);
        @(negedge CLK);
        chk({ss, sl}, 2'h1);
        wb(1'h1, 8'h10, 32'h0000_0010);
        {pm, want[2], want[0]} <= 3'h3;
        repeat (40) @(posedge CLK);
        @(negedge CLK);
        chk(pse, 1);
        @(posedge CLK);
        want[0] <= 1'h0;
        repeat (30) @(posedge CLK);
        wb(1'h1, 8'h10, 32'h0000_0000);
        // Interrupt on alarm clear rise, then cleared and masked off
        wb(1'h1, 8'h2C, 32'h0000_000F);
        wb(1'h1, 8'h30, 32'h0000_0004);
        @(negedge CLK);
        chk(irq, 0);
        for (int i = 0; i < 5; i++) begin
            ms(0, 16'(i % 4) | ((i == 4) ? 16'h0010 : 16'h0000), fc(i % 4) + ((i == 4) ? 40 : 0));
            if (i == 0) begin
                chk(irq, 1);
                wb(1'h1, 8'h2C, 32'h0000_0004);
                wb(1'h1, 8'h30, 32'h0000_0000);
                @(negedge CLK);
                chk(irq, 0);
            end
        end
        wb(1'h0, 8'h2C, 32'h0000_0000);
        @(negedge CLK);
        chk({irq, q[2]}, 2'h1);
        ms(1, 16'h0101, fc(1) + 40);
        wb(1'h1, 8'h18, 32'h0000_0001);
        want[1] <= 1'h1;
        wt(1, 1'h1, 60);
        repeat (10) @(negedge CLK);
        chk(dc, 1);
        wb(1'h1, 8'h0C, 32'h0000_0002);
        {want[1], chat} <= 5'h01;
        g = 0;
        repeat (40) begin
            @(negedge CLK);
            g = g | !pse;
        end
        chk(g, 0);
        tally_and_finish();
    end
endmodule
